// ==== rtl/windowed_supervision_timer.sv ====
// windowed supervision timer with early warning, single clock domain
module windowed_supervision_timer (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic count_clk,
    input wire logic count_clk_running,
    input wire logic bus_clk_en,
    input wire logic debug_halt,
    input wire logic guard_lock,
    input wire logic ctrl_wr,
    input wire sup_timer_pkg::ctrl_s ctrl_in,
    input wire sup_timer_pkg::service_s service_in,
    input wire logic ew_ien_set,
    input wire logic ew_ien_clr,
    input wire logic flag_clr,
    output logic sys_reset_req,
    output logic irq,
    output logic timer_enabled,
    output logic ew_flag,
    output logic window_open,
    output logic [sup_timer_pkg::CNT_W-1:0] count_value
);
    import sup_timer_pkg::*;

    // =====================================
    // reset release
    logic [1:0] rst_pipe_r;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_pipe_r <= 2'b00;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_r[1];

    // =====================================
    // state
    state_s st_r;
    state_s st_nxt;
    logic tick;
    logic bus_ok;
    logic svc;
    logic key_ok;
    logic [CNT_W-1:0] per_len;
    logic [CNT_W-1:0] win_len;
    logic [CNT_W-1:0] ew_len;
    logic [CNT_W-1:0] cnt_inc;

    // sync[0] feeds only sync[1]; edge taken between sync[1] and sync[2]
    assign tick = st_r.sync[1] & ~st_r.sync[2] & count_clk_running & ~debug_halt;
    assign bus_ok = bus_clk_en & ~guard_lock;
    assign svc = service_in.wr & bus_ok & st_r.cfg.enable;
    assign key_ok = (service_in.data == SERVICE_KEY);
    assign per_len = period_len(st_r.cfg.per);
    assign win_len = period_len(st_r.cfg.window);
    assign ew_len = period_len(st_r.cfg.ew_offset);
    assign cnt_inc = st_r.cnt + 15'h0001;

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync = {st_r.sync[1:0], count_clk};

        if (bus_ok && ew_ien_set) begin
            st_nxt.ew_ien = 1'b1;
        end else if (bus_ok && ew_ien_clr) begin
            st_nxt.ew_ien = 1'b0;
        end
        // flag clear stays open under the guard; a set below wins
        if (bus_clk_en && flag_clr) begin
            st_nxt.ew_flag = 1'b0;
        end

        case (st_r.phase)
            ST_CLOSED: begin
                if (svc) begin
                    st_nxt.reset_req = 1'b1;
                end else if (tick) begin
                    if (st_r.cnt == win_len - 15'h0001) begin
                        st_nxt.phase = ST_OPEN;
                        st_nxt.cnt = '0;
                        if (st_r.ew_ien) begin
                            st_nxt.ew_flag = 1'b1;
                        end
                    end else begin
                        st_nxt.cnt = cnt_inc;
                    end
                end
            end
            ST_OPEN: begin
                if (svc) begin
                    if (!key_ok) begin
                        st_nxt.reset_req = 1'b1;
                    end else begin
                        st_nxt.cnt = '0;
                        st_nxt.phase = st_r.cfg.window_en ? ST_CLOSED : ST_OPEN;
                    end
                end else if (tick) begin
                    if (st_r.cnt == per_len - 15'h0001) begin
                        st_nxt.reset_req = 1'b1;
                    end else begin
                        st_nxt.cnt = cnt_inc;
                    end
                    if (!st_r.cfg.window_en && st_r.ew_ien && cnt_inc == ew_len) begin
                        st_nxt.ew_flag = 1'b1;
                    end
                end
            end
            default: begin
                st_nxt.cnt = '0;
            end
        endcase

        if (ctrl_wr && bus_ok) begin
            // protected fields only load while off and staying off
            if (!st_r.cfg.enable && !ctrl_in.enable) begin
                st_nxt.cfg.window_en = ctrl_in.window_en;
                st_nxt.cfg.always_on = ctrl_in.always_on;
                st_nxt.cfg.per = ctrl_in.per;
                st_nxt.cfg.window = ctrl_in.window;
                st_nxt.cfg.ew_offset = ctrl_in.ew_offset;
            end
            if (ctrl_in.enable) begin
                st_nxt.cfg.enable = 1'b1;
            end else if (!st_r.cfg.always_on) begin
                st_nxt.cfg.enable = 1'b0;
            end
        end
        if (!st_r.cfg.enable && st_nxt.cfg.enable) begin
            st_nxt.phase = st_r.cfg.window_en ? ST_CLOSED : ST_OPEN;
            st_nxt.cnt = '0;
        end else if (!st_nxt.cfg.enable) begin
            st_nxt.phase = ST_OFF;
            st_nxt.cnt = '0;
        end

        st_nxt.irq = st_nxt.ew_flag & st_nxt.ew_ien;
        st_nxt.win_open = (st_nxt.phase == ST_OPEN);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sys_reset_req = st_r.reset_req;
    assign irq = st_r.irq;
    assign timer_enabled = st_r.cfg.enable;
    assign ew_flag = st_r.ew_flag;
    assign window_open = st_r.win_open;
    assign count_value = st_r.cnt;

    // =====================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence closed_expires;
        st_r.phase == ST_CLOSED && !svc && tick && st_r.cnt == win_len - 15'h0001;
    endsequence

    sequence open_expires;
        st_r.phase == ST_OPEN && !svc && tick && st_r.cnt == per_len - 15'h0001;
    endsequence

    sequence good_service;
        st_r.phase == ST_OPEN && svc && key_ok && !ctrl_wr;
    endsequence

    sequence enable_write;
        !st_r.cfg.enable && ctrl_wr && bus_ok && ctrl_in.enable;
    endsequence

    sequence closed_tick;
        st_r.phase == ST_CLOSED && !svc && !ctrl_wr && tick && st_r.cnt != win_len - 15'h0001;
    endsequence

    sequence open_tick;
        st_r.phase == ST_OPEN && !svc && !ctrl_wr && tick && st_r.cnt != per_len - 15'h0001;
    endsequence

    sequence locked_write;
        guard_lock && (ctrl_wr || ew_ien_set || ew_ien_clr);
    endsequence

    sequence flag_cleared;
        bus_clk_en && flag_clr && !tick;
    endsequence

    AST_TIMEOUT_RESET: assert property (open_expires |=> sys_reset_req [*3])
        else $error("time-out did not raise reset request");
    AST_EARLY_SERVICE: assert property (st_r.phase == ST_CLOSED && svc |=> sys_reset_req)
        else $error("service in closed window did not reset");
    AST_BAD_KEY: assert property (svc && !key_ok |=> sys_reset_req)
        else $error("wrong service key did not reset");
    AST_RESTART: assert property (good_service |=> count_value == 15'h0000
        && window_open == !$past(st_r.cfg.window_en))
        else $error("valid service did not restart period");
    AST_WINDOW_EW: assert property (closed_expires ##0 st_r.ew_ien && !ctrl_wr && !ew_ien_clr
        |=> ew_flag && irq && window_open)
        else $error("early warning missing at window open");
    AST_NORMAL_EW: assert property (st_r.phase == ST_OPEN && !st_r.cfg.window_en && !svc
        && tick && st_r.ew_ien && cnt_inc == ew_len |=> ew_flag)
        else $error("normal early warning not flagged");
    AST_FLAG_STICKY: assert property (ew_flag && !flag_clr |=> ew_flag)
        else $error("early-warning flag dropped without clear");
    AST_HALT_FREEZE: assert property (debug_halt && st_r.phase == ST_OPEN && !svc && !ctrl_wr
        |=> $stable(count_value))
        else $error("count moved during debug halt");
    AST_PROTECTED: assert property (timer_enabled && ctrl_wr |=> $stable(st_r.cfg.per)
        && $stable(st_r.cfg.window_en))
        else $error("protected config changed while enabled");
    AST_GUARD: assert property (guard_lock && !svc |=> $stable(st_r.cfg))
        else $error("locked configuration changed");
    AST_IRQ_LINE: assert property (ew_flag && st_r.ew_ien && !flag_clr && !ew_ien_clr
        |=> irq)
        else $error("interrupt line not raised");

    // =====================================
    // counting, gating, enable, reset-request and early-warning checks

    AST_RESET_HOLD: assert property (sys_reset_req |=> sys_reset_req)
        else $error("reset request dropped before reset");

    AST_OFF_IDLE: assert property (!timer_enabled |-> count_value == 15'h0000 && !window_open)
        else $error("stopped timer not idle");

    AST_OFF_NO_RESET: assert property (!timer_enabled && !sys_reset_req |=> !sys_reset_req)
        else $error("stopped timer requested reset");

    AST_ENABLE_START: assert property (enable_write |=> timer_enabled && count_value == 15'h0000)
        else $error("enable did not start a fresh period");

    AST_CLOSED_COUNT: assert property (closed_tick |=> !window_open
        && count_value == $past(count_value) + 15'h0001)
        else $error("closed window count did not step");

    AST_OPEN_COUNT: assert property (open_tick |=> count_value == $past(count_value) + 15'h0001)
        else $error("open period count did not step");

    AST_CLOSED_BOUND: assert property (st_r.phase == ST_CLOSED |-> count_value < win_len)
        else $error("closed window count past its length");

    AST_OPEN_BOUND: assert property (st_r.phase == ST_OPEN |-> count_value < per_len)
        else $error("open period count past its length");

    AST_NORMAL_OPEN: assert property (timer_enabled && !st_r.cfg.window_en && !ctrl_wr
        |=> window_open)
        else $error("normal mode left the open phase");

    AST_WINDOW_REOPEN: assert property (closed_expires ##0 !ctrl_wr
        |=> window_open && count_value == 15'h0000)
        else $error("window did not open after closed period");

    AST_SERVICE_OK: assert property (good_service ##0 !sys_reset_req |=> !sys_reset_req)
        else $error("valid service raised reset");

    AST_CLOCK_STOP: assert property (!count_clk_running && !svc && !ctrl_wr
        |=> $stable(count_value))
        else $error("count moved without count clock");

    AST_BUS_GATED: assert property (!bus_clk_en |=> $stable(st_r.cfg)
        && $stable(st_r.ew_ien))
        else $error("write taken with bus clock off");

    AST_LOCKED_WRITE: assert property (locked_write |=> $stable(st_r.ew_ien)
        && $stable(timer_enabled))
        else $error("locked write changed enable state");

    AST_DISABLE_BLOCKED: assert property (timer_enabled && st_r.cfg.always_on
        |=> timer_enabled)
        else $error("always-on timer was disabled");

    AST_IEN_SET: assert property (bus_ok && ew_ien_set |=> st_r.ew_ien)
        else $error("early-warning enable not set");

    AST_IEN_CLR: assert property (bus_ok && ew_ien_clr && !ew_ien_set
        |=> !st_r.ew_ien && !irq)
        else $error("early-warning enable not cleared");

    AST_FLAG_CLEAR: assert property (flag_cleared |=> !ew_flag && !irq)
        else $error("early-warning flag not cleared");

    AST_SET_WINS: assert property (closed_expires ##0 st_r.ew_ien && flag_clr && !ctrl_wr
        |=> ew_flag)
        else $error("flag clear beat a flag set");

    AST_IRQ_QUIET: assert property (!ew_flag |-> !irq)
        else $error("interrupt without early-warning flag");

endmodule : windowed_supervision_timer

// ==== pkg/sup_timer_pkg.sv ====
// constants, carrier structs and helpers of the supervision timer
package sup_timer_pkg;

    // =====================================
    // constants
    localparam logic [7:0] SERVICE_KEY = 8'hA5;
    localparam int CNT_W = 15;
    localparam logic [3:0] PERIOD_CODE_MAX = 4'hB;
    localparam logic [CNT_W-1:0] PERIOD_BASE = 15'h0008;
    localparam logic [3:0] PER_RST = 4'hB;
    localparam logic [3:0] WINDOW_RST = 4'hB;
    localparam logic [3:0] EW_OFFSET_RST = 4'hA;

    // =====================================
    // types
    typedef enum logic [1:0] {ST_OFF, ST_CLOSED, ST_OPEN} phase_e;

    typedef struct packed {
        logic enable;
        logic window_en;
        logic always_on;
        logic [3:0] per;
        logic [3:0] window;
        logic [3:0] ew_offset;
    } ctrl_s;

    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } service_s;

    typedef struct packed {
        logic [2:0] sync;
        phase_e phase;
        logic [CNT_W-1:0] cnt;
        ctrl_s cfg;
        logic ew_ien;
        logic ew_flag;
        logic irq;
        logic reset_req;
        logic win_open;
    } state_s;

    localparam ctrl_s CTRL_RST = '{enable: 1'b0, window_en: 1'b0, always_on: 1'b0,
        per: PER_RST, window: WINDOW_RST, ew_offset: EW_OFFSET_RST};
    localparam state_s STATE_RST = '{sync: 3'h0, phase: ST_OFF, cnt: 15'h0000,
        cfg: CTRL_RST, ew_ien: 1'b0, ew_flag: 1'b0, irq: 1'b0, reset_req: 1'b0,
        win_open: 1'b0};

    // period length in count-clock cycles, 8 << code, codes above max clamp
    function automatic logic [CNT_W-1:0] period_len(input logic [3:0] code);
        logic [3:0] c;
        c = (code > PERIOD_CODE_MAX) ? PERIOD_CODE_MAX : code;
        return PERIOD_BASE << c;
    endfunction : period_len

endpackage : sup_timer_pkg

// ==== verification/count_clock_src.sv ====
// partner model: count clock source plus reset and interrupt receiver
module count_clock_src (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clock_on,
    input wire logic sys_reset_req,
    input wire logic irq,
    output logic count_clk,
    output logic reset_seen,
    output logic irq_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    int phase = 0;
    initial count_clk = 1'b0;
    // stands low while off, else 4 sys_clk high and 4 low
    always @(posedge sys_clk) begin
        phase <= (!clock_on || phase == 3) ? 0 : phase + 1;
        if (!clock_on) count_clk <= 1'b0;
        else if (phase == 3) count_clk <= ~count_clk;
    end
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reset_seen <= 1'b0;
            irq_seen <= 1'b0;
        end else begin
            reset_seen <= reset_seen | sys_reset_req;
            irq_seen <= irq_seen | irq;
        end
    end
endmodule : count_clock_src

// ==== verification/tb_top.sv ====
// self-checking bench of the windowed supervision timer
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sup_timer_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst, count_clk, clk_run, bus_en, dbg, lock, ctrl_wr, ien_set, ien_clr, fclr;
    logic clock_on, rst_req, irq, en, flag, wopen, reset_seen, irq_seen;
    logic [7:0] key;
    logic [CNT_W-1:0] cnt;
    ctrl_s ctrl;
    service_s svc;
    int n_mismatch = 0;
    int checked = 0;
    int edges = 0;
    int edge_base = 0;
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    // model: count clock edges seen since time zero; start records edge_base
    always @(posedge count_clk) edges <= edges + 1;
    windowed_supervision_timer i_dut (.sys_clk(sys_clk), .nrst(nrst), .count_clk(count_clk),
        .count_clk_running(clk_run), .bus_clk_en(bus_en), .debug_halt(dbg), .guard_lock(lock),
        .ctrl_wr(ctrl_wr), .ctrl_in(ctrl), .service_in(svc), .ew_ien_set(ien_set),
        .ew_ien_clr(ien_clr), .flag_clr(fclr), .sys_reset_req(rst_req), .irq(irq),
        .timer_enabled(en), .ew_flag(flag), .window_open(wopen), .count_value(cnt));
    count_clock_src i_src (.sys_clk(sys_clk), .nrst(nrst), .clock_on(clock_on),
        .sys_reset_req(rst_req), .irq(irq), .count_clk(count_clk), .reset_seen(reset_seen),
        .irq_seen(irq_seen));
    // ==========================================
    // tasks
    function automatic int exp_len(input int code);
        return 8 << ((code > 11) ? 11 : code);
    endfunction : exp_len
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask : cyc
    task automatic wait_hi(ref logic s, input int lim);
        int i;
        for (i = 0; i < lim && s !== 1'b1; i++) cyc(1);
        if (i == lim) begin
            chk(s, 1'b1);
            print_verdict();
        end
    endtask : wait_hi
    task automatic pulse_ctrl(input ctrl_s c);
        ctrl = c;
        ctrl_wr = 1'b1;
        cyc(1);
        ctrl_wr = 1'b0;
    endtask : pulse_ctrl
    task automatic service(input logic [7:0] d);
        svc = '{wr: 1'b1, data: d};
        cyc(1);
        svc.wr = 1'b0;
    endtask : service
    task automatic do_reset(input logic ien);
        nrst = 1'b0;
        clock_on = 1'b0;
        cyc(10);
        nrst = 1'b1;
        cyc(3);
        chk({rst_req, irq, en, flag, wopen, cnt}, 32'h0000_0000);
        ien_set = ien;
        cyc(1);
        ien_set = 1'b0;
    endtask : do_reset
    task automatic start(input logic wen, input logic [3:0] per, input logic [3:0] win);
        ctrl_s c;
        c = '{enable: 1'b0, window_en: wen, always_on: 1'b0, per: per, window: win,
            ew_offset: 4'h0};
        pulse_ctrl(c);
        cyc(1);
        c.enable = 1'b1;
        pulse_ctrl(c);
        chk({en, wopen}, {1'b1, !wen});
        edge_base = edges;
        clock_on = 1'b1;
    endtask : start
    // ==========================================
    // main sequence
    initial begin
        {nrst, dbg, lock, ctrl_wr, ien_set, ien_clr, fclr, clock_on} = 8'h00;
        {clk_run, bus_en} = 2'h3;
        ctrl = CTRL_RST;
        svc = '0;
        void'($urandom(8));
        do_reset(1'b0);
        start(1'b0, 4'h0, 4'h0);
        wait_hi(rst_req, exp_len(0) * 8 + 20);
        chk(edges - edge_base, exp_len(0));
        cyc(1);
        chk(reset_seen, 1'b1);
        $display("test normal timeout done");
        do_reset(1'b0);
        start(1'b0, 4'h3, 4'h0);
        cyc(20);
        key = 8'($urandom);
        if (key == SERVICE_KEY) key = 8'h5A;
        service(key);
        chk(rst_req, 1'b1);
        $display("test wrong key done");
        do_reset(1'b1);
        start(1'b0, 4'h1, 4'h0);
        wait_hi(flag, exp_len(0) * 8 + 20);
        chk(edges - edge_base, exp_len(0));
        chk(irq, 1'b1);
        cyc(5);
        chk({flag, irq_seen}, 2'h3);
        lock = 1'b1;
        pulse_ctrl(CTRL_RST);
        chk(en, 1'b1);
        fclr = 1'b1;
        cyc(1);
        fclr = 1'b0;
        chk({flag, irq}, 2'h0);
        lock = 1'b0;
        ien_clr = 1'b1;
        cyc(1);
        ien_clr = 1'b0;
        service(SERVICE_KEY);
        chk({cnt, rst_req}, 16'h0000);
        $display("test normal early warning done");
        do_reset(1'b1);
        start(1'b1, 4'h0, 4'h1);
        wait_hi(wopen, exp_len(1) * 8 + 20);
        chk(edges - edge_base, exp_len(1));
        chk(flag, 1'b1);
        service(SERVICE_KEY);
        chk({cnt, wopen, rst_req}, 17'h0_0000);
        cyc(2);
        service(SERVICE_KEY);
        chk(rst_req, 1'b1);
        $display("test window done");
        do_reset(1'b0);
        dbg = 1'b1;
        start(1'b0, 4'h0, 4'h0);
        cyc(100);
        chk({cnt, rst_req}, 16'h0000);
        dbg = 1'b0;
        clk_run = 1'b0;
        cyc(100);
        chk({cnt, rst_req}, 16'h0000);
        clk_run = 1'b1;
        bus_en = 1'b0;
        service(8'h00);
        chk(rst_req, 1'b0);
        bus_en = 1'b1;
        lock = 1'b1;
        service(8'h00);
        chk(rst_req, 1'b0);
        lock = 1'b0;
        wait_hi(rst_req, exp_len(0) * 8 + 40);
        chk(rst_req, 1'b1);
        $display("test halt and gating done");
        print_verdict();
    end
endmodule : tb_top
